// file: sdid_pkg.sv
// Package for the servo drive input decoder: register map, fields, codes
package sdid_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00; // Mode settings
  localparam logic [7:0] ADDR_INSEL0 = 8'h04; // First pin selector, five more follow
  localparam logic [7:0] ADDR_STATUS = 8'h1C; // Decoded function levels
  localparam logic [7:0] ADDR_ALARM = 8'h20; // Alarm state and code
  localparam logic [7:0] ADDR_INT_STAT = 8'h24; // Sticky events, write one to clear
  localparam logic [7:0] ADDR_INT_MASK = 8'h28; // Event enables
  localparam logic [7:0] ADDR_STEP = 8'h04; // Word spacing

  // ----------------------------------------------------------------
  // Input functions that a general pin can carry
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 6;
  localparam int NUM_FN = 14;
  localparam logic [3:0] FN_NONE = 4'h0;
  localparam logic [3:0] FN_DRIVE_EN = 4'h1;
  localparam logic [3:0] FN_ALARM_CLR = 4'h2;
  localparam logic [3:0] FN_DEV_CLR = 4'h3;
  localparam logic [3:0] FN_INHIBIT = 4'h4;
  localparam logic [3:0] FN_NEG_LIMIT = 4'h5;
  localparam logic [3:0] FN_POS_LIMIT = 4'h6;
  localparam logic [3:0] FN_SCALE_A = 4'h7;
  localparam logic [3:0] FN_SCALE_B = 4'h8;
  localparam logic [3:0] FN_DAMP_A = 4'h9;
  localparam logic [3:0] FN_DAMP_B = 4'hA;
  localparam logic [3:0] FN_GAIN = 4'hB;
  localparam logic [3:0] FN_TORQUE = 4'hC;
  localparam logic [3:0] FN_FORCED = 4'hD;
  localparam int PIN_DEV_CLR = 2; // Third general input, fixed function
  localparam int PIN_INHIBIT = 3; // Fourth general input, fixed function

  // ----------------------------------------------------------------
  // Mode encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] TRAVEL_RESTRICT = 2'h0; // Block motion toward the limit
  localparam logic [1:0] TRAVEL_IGNORE = 2'h1; // Limit inputs have no effect
  localparam logic [1:0] TRAVEL_ALARM = 2'h2; // Limit raises an alarm
  localparam logic [1:0] CLR_LEVEL = 2'h0; // Clear while input is on
  localparam logic [1:0] CLR_EDGE = 2'h1; // Clear on rising edge
  localparam logic [1:0] CLR_OFF = 2'h2; // Clear input disabled

  // Alarm codes: main number in bits 11:4, sub number in 3:0
  localparam logic [11:0] ALM_FORCED = 12'h570; // 87.0
  localparam logic [11:0] ALM_TRAVEL = 12'h260; // 38.0

  // Event bits
  localparam int EV_ALARM = 0;
  localparam int EV_DEV_CLR = 1;
  localparam int EV_POS_LIM = 2;
  localparam int EV_NEG_LIM = 3;
  localparam int NUM_EV = 4;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic inhibit_invalidation; // Bit 5: one ignores the pulse inhibit
    logic [1:0] counter_clear_mode; // Bits 4:3
    logic [1:0] travel_inhibit_setting; // Bits 2:1
    logic line_driver_en; // Bit 0: accept line driver pulses
  } sdid_ctrl_t;

  localparam sdid_ctrl_t CTRL_RESET = '{inhibit_invalidation: 1'b1, counter_clear_mode: CLR_EDGE,
                                        travel_inhibit_setting: TRAVEL_IGNORE, line_driver_en: 1'b0};

  typedef struct packed {
    logic invert; // Bit 4: input active when off
    logic [3:0] func; // Bits 3:0
  } sdid_insel_t;

  typedef struct packed {
    logic [NUM_FN-1:0] fn_level; // One bit per function
  } sdid_status_t;

endpackage // sdid_pkg

// file: sdid_decoder.sv
// Servo drive input decoder: pin mapping, command gating, alarm logic, APB registers
//
// Functional notes
// - Line driver pulses ignored at default setting
// - Drive enable input switches motor power
// - Positive limit acts per travel setting
// - Negative limit acts per travel setting
// - Deviation clear on edges, mode selectable
// - Alarm clear input, some alarms latched
// - Inhibit blocks pulses when invalidation zero
// - Two scaling selectors pick numerator
// - Two damping selectors form frequency code
// - Gain selector picks first or second
// - Torque selector picks first or second limit
// - Forced alarm input raises code 87.0
// - Six selectors map function and sense
// - Clear fixed on pin three, inhibit four
// - Selector pin p defaults to function p+1
// - Alarm output on normally, off on alarm
//
// Register access over APB and the register addresses were chosen for this implementation.
module sdid_decoder #(
  parameter int PINS = sdid_pkg::NUM_PINS
) (
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [PINS-1:0] general_in,
  input wire logic cmd_pulse_pos,
  input wire logic cmd_pulse_neg,
  input wire logic cmd_dir_pos,
  input wire logic cmd_dir_neg,
  // Drive fault sources outside this block
  input wire logic fault_req,
  input wire logic [11:0] fault_code,
  input wire logic fault_clearable,
  // Decoded outputs
  output logic motor_power_en,
  output logic cmd_step,
  output logic cmd_step_dir,
  output logic stop_pos,
  output logic stop_neg,
  output logic deviation_clear,
  output logic [1:0] scaling_sel,
  output logic [1:0] damping_sel,
  output logic gain_sel,
  output logic torque_limit_sel,
  output logic alarm_out,
  output logic [11:0] alarm_code,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int NSYNC = PINS + 4; // Pins plus four command lines
  logic [NSYNC-1:0] sync_a; // First stage, read only by second
  logic [NSYNC-1:0] sync_b; // Second stage
  logic [PINS-1:0] pin_s; // Synchronised general pins
  logic pulse_s; // Synchronised command pulse
  logic dir_s; // Synchronised direction
  logic pulse_d; // Previous pulse level
  sdid_pkg::sdid_ctrl_t ctrl; // Mode register
  sdid_pkg::sdid_insel_t insel [PINS]; // Pin selectors
  sdid_pkg::sdid_insel_t insel_eff [PINS]; // Selectors after fixed pins
  sdid_pkg::sdid_status_t status; // Function levels
  sdid_pkg::sdid_status_t status_d; // Previous levels for edges
  logic [sdid_pkg::NUM_EV-1:0] int_stat; // Sticky events
  logic [sdid_pkg::NUM_EV-1:0] int_mask; // Event enables
  logic [sdid_pkg::NUM_EV-1:0] ev; // Events this cycle
  logic alarm_active; // Alarm state
  logic alarm_fixed; // Alarm cannot be cleared by input
  logic raise; // Some alarm source requests now
  logic [11:0] raise_code; // Code of the winning source
  logic raise_fixed; // Winning source latches
  logic clr_edge; // Alarm clear rising edge
  logic dev_edge; // Deviation clear rising edge
  logic wr; // APB write access
  logic rd; // APB read access
  logic hit; // Address is mapped
  logic [31:0] rdata; // Read mux
  logic [PINS-1:0] insel_hit; // Selector decode

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // two flop stages
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {cmd_dir_neg, cmd_dir_pos, cmd_pulse_neg, cmd_pulse_pos, general_in};
      sync_b <= sync_a;
    end
  end

  assign pin_s = sync_b[PINS-1:0];

  // Line driver pair read differentially: high only when the positive line is high and the negative line low
  assign pulse_s = sync_b[PINS] & ~sync_b[PINS+1];
  assign dir_s = sync_b[PINS+2] & ~sync_b[PINS+3];

  // ----------------------------------------------------------------
  // Function mapping
  // ----------------------------------------------------------------
  // fixed pins keep their function, only sense may change
  always_comb
  begin
    for (int p = 0; p < PINS; p++)
    begin
      insel_eff[p] = insel[p];
      if (p == sdid_pkg::PIN_DEV_CLR)
        insel_eff[p].func = sdid_pkg::FN_DEV_CLR;
      else if (p == sdid_pkg::PIN_INHIBIT)
        insel_eff[p].func = sdid_pkg::FN_INHIBIT;
      else if (insel[p].func == sdid_pkg::FN_DEV_CLR || insel[p].func == sdid_pkg::FN_INHIBIT)
        insel_eff[p].func = sdid_pkg::FN_NONE;
      else
        insel_eff[p].func = insel[p].func;
    end
  end

  // each function is on when any pin mapped to it is active
  for (genvar f = 0; f < sdid_pkg::NUM_FN; f++)
  begin : g_fn
    always_comb
    begin
      status.fn_level[f] = 1'b0;
      if (f != 0)
      begin
        for (int p = 0; p < PINS; p++)
        begin
          if (insel_eff[p].func == 4'(f))
            status.fn_level[f] = status.fn_level[f] | (pin_s[p] ^ insel_eff[p].invert);
        end
      end
    end
  end

  // Previous levels for edge detection
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_d <= '0;
      pulse_d <= 1'b0;
    end
    else
    begin
      status_d <= status;
      pulse_d <= pulse_s;
    end
  end

  assign clr_edge = status.fn_level[sdid_pkg::FN_ALARM_CLR] & ~status_d.fn_level[sdid_pkg::FN_ALARM_CLR];
  assign dev_edge = status.fn_level[sdid_pkg::FN_DEV_CLR] & ~status_d.fn_level[sdid_pkg::FN_DEV_CLR];

  // ----------------------------------------------------------------
  // Alarm sources
  // ----------------------------------------------------------------
  // Forced alarm wins over travel, travel over outside faults
  always_comb
  begin
    raise = 1'b1;
    raise_code = sdid_pkg::ALM_FORCED;
    raise_fixed = 1'b0;
    if (status.fn_level[sdid_pkg::FN_FORCED])
      raise_code = sdid_pkg::ALM_FORCED;
    else if (ctrl.travel_inhibit_setting == sdid_pkg::TRAVEL_ALARM &&
             (status.fn_level[sdid_pkg::FN_POS_LIMIT] || status.fn_level[sdid_pkg::FN_NEG_LIMIT]))
      raise_code = sdid_pkg::ALM_TRAVEL;
    else if (fault_req)
    begin
      raise_code = fault_code;
      raise_fixed = ~fault_clearable;
    end
    else
      raise = 1'b0;
  end

  // Alarm state; a request in the clear cycle keeps the alarm
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alarm_active <= 1'b0;
      alarm_fixed <= 1'b0;
      alarm_code <= '0;
    end
    else if (raise && !alarm_active)
    begin
      alarm_active <= 1'b1;
      alarm_fixed <= raise_fixed;
      alarm_code <= raise_code;
    end
    else if (raise && raise_fixed)
      alarm_fixed <= 1'b1;
    // clear unless latched or still requested
    else if (alarm_active && clr_edge && !alarm_fixed && !raise)
    begin
      alarm_active <= 1'b0;
      alarm_code <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------
  // Motor power, limits, clear and selectors
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      motor_power_en <= 1'b0;
      stop_pos <= 1'b0;
      stop_neg <= 1'b0;
      deviation_clear <= 1'b0;
      scaling_sel <= '0;
      damping_sel <= '0;
      gain_sel <= 1'b0;
      torque_limit_sel <= 1'b0;
      alarm_out <= 1'b0;
    end
    else
    begin
      // power follows drive enable, dropped under alarm
      motor_power_en <= status.fn_level[sdid_pkg::FN_DRIVE_EN] & ~alarm_active;
      stop_pos <= (ctrl.travel_inhibit_setting != sdid_pkg::TRAVEL_IGNORE) &
                  status.fn_level[sdid_pkg::FN_POS_LIMIT];
      stop_neg <= (ctrl.travel_inhibit_setting != sdid_pkg::TRAVEL_IGNORE) &
                  status.fn_level[sdid_pkg::FN_NEG_LIMIT];
      // clear by edge or level per mode
      case (ctrl.counter_clear_mode)
        sdid_pkg::CLR_LEVEL: deviation_clear <= status.fn_level[sdid_pkg::FN_DEV_CLR];
        sdid_pkg::CLR_EDGE: deviation_clear <= dev_edge;
        default: deviation_clear <= 1'b0;
      endcase
      scaling_sel <= {status.fn_level[sdid_pkg::FN_SCALE_B], status.fn_level[sdid_pkg::FN_SCALE_A]};
      damping_sel <= {status.fn_level[sdid_pkg::FN_DAMP_B], status.fn_level[sdid_pkg::FN_DAMP_A]};
      gain_sel <= status.fn_level[sdid_pkg::FN_GAIN];
      torque_limit_sel <= status.fn_level[sdid_pkg::FN_TORQUE];
      // on in normal state, off under alarm
      alarm_out <= ~alarm_active;
    end
  end

  // Command pulse stepping
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd_step <= 1'b0;
      cmd_step_dir <= 1'b0;
    end
    else
    begin
      // direction held while line driver off
      if (ctrl.line_driver_en)
        cmd_step_dir <= dir_s;
      // ignored unless line driver input enabled
      // inhibit blocks pulses when invalidation is zero
      cmd_step <= ctrl.line_driver_en & pulse_s & ~pulse_d & ~alarm_active &
                  ~(status.fn_level[sdid_pkg::FN_INHIBIT] & ~ctrl.inhibit_invalidation) &
                  ~(dir_s ? stop_pos : stop_neg);
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign ev[sdid_pkg::EV_ALARM] = raise & ~alarm_active;
  assign ev[sdid_pkg::EV_DEV_CLR] = dev_edge;
  assign ev[sdid_pkg::EV_POS_LIM] = status.fn_level[sdid_pkg::FN_POS_LIMIT] &
                                    ~status_d.fn_level[sdid_pkg::FN_POS_LIMIT];
  assign ev[sdid_pkg::EV_NEG_LIM] = status.fn_level[sdid_pkg::FN_NEG_LIMIT] &
                                    ~status_d.fn_level[sdid_pkg::FN_NEG_LIMIT];

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      int_stat <= '0;
    else if (wr && paddr == sdid_pkg::ADDR_INT_STAT)
      int_stat <= (int_stat & ~pwdata[sdid_pkg::NUM_EV-1:0]) | ev;
    else
      int_stat <= int_stat | ev;
  end

  // Level interrupt
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(int_stat & int_mask);
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;

  for (genvar p = 0; p < PINS; p++)
  begin : g_insel
    assign insel_hit[p] = (paddr == 8'(sdid_pkg::ADDR_INSEL0 + p * sdid_pkg::ADDR_STEP));

    // Selector register; default maps pin p to the (p+1)-th basic function
    // selector p starts at function p+1, not inverted
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        insel[p].invert <= 1'b0;
        insel[p].func <= 4'(p + 1);
      end
      else if (wr && insel_hit[p])
        insel[p] <= pwdata[4:0];
    end
  end

  // Control register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl <= sdid_pkg::CTRL_RESET;
      int_mask <= '0;
    end
    else if (wr && paddr == sdid_pkg::ADDR_CTRL)
      ctrl <= pwdata[5:0];
    else if (wr && paddr == sdid_pkg::ADDR_INT_MASK)
      int_mask <= pwdata[sdid_pkg::NUM_EV-1:0];
  end

  // Read mux and address decode
  always_comb
  begin
    rdata = '0;
    hit = 1'b1;
    case (paddr)
      sdid_pkg::ADDR_CTRL: rdata = {26'h0, ctrl};
      sdid_pkg::ADDR_STATUS: rdata = {18'h0, status};
      sdid_pkg::ADDR_ALARM: rdata = {18'h0, alarm_fixed, alarm_active, alarm_code};
      sdid_pkg::ADDR_INT_STAT: rdata = {28'h0, int_stat};
      sdid_pkg::ADDR_INT_MASK: rdata = {28'h0, int_mask};
      default:
      begin
        hit = |insel_hit;
        for (int p = 0; p < PINS; p++)
        begin
          if (insel_hit[p])
            rdata = {27'h0, insel[p]};
        end
      end
    endcase
  end

  assign pslverr = psel & penable & ~hit;
  assign prdata = (rd && hit) ? rdata : 32'h0000_0000;

endmodule // sdid_decoder

// file: sdid_decoder_assertions.sv
// Port checker and bind for the servo drive input decoder
module sdid_decoder_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic fault_req,
  input wire logic motor_power_en,
  input wire logic cmd_step,
  input wire logic cmd_step_dir,
  input wire logic stop_pos,
  input wire logic stop_neg,
  input wire logic alarm_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Output relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_power; !alarm_out [*2] |-> !motor_power_en; endproperty
  a_power: assert property (p_power) else $error("motor power during alarm");
  property p_step_pulse; cmd_step |=> !cmd_step; endproperty
  a_step_pulse: assert property (p_step_pulse) else $error("step longer than one cycle");
  property p_stop_pos; cmd_step && cmd_step_dir |-> !stop_pos; endproperty
  a_stop_pos: assert property (p_stop_pos) else $error("step into positive limit");
  property p_stop_neg; cmd_step && !cmd_step_dir |-> !stop_neg; endproperty
  a_stop_neg: assert property (p_stop_neg) else $error("step into negative limit");
  property p_fault; $rose(fault_req) |-> ##[1:4] !alarm_out; endproperty
  a_fault: assert property (p_fault) else $error("fault did not drop alarm output");
  property p_hold; !alarm_out && fault_req && $past(nrst) |=> !alarm_out; endproperty
  a_hold: assert property (p_hold) else $error("alarm left while source active");
  property p_unmapped; psel && penable && paddr >= 8'h2C |-> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_idle; !psel |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("bus outputs active while idle");

  // Main scenarios reached
  c_step: cover property (cmd_step);
  c_alarm: cover property ($fell(alarm_out));
  c_irq: cover property (irq);
endmodule // sdid_decoder_chk

bind sdid_decoder sdid_decoder_chk u_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pslverr(pslverr), .fault_req(fault_req), .motor_power_en(motor_power_en), .cmd_step(cmd_step),
  .cmd_step_dir(cmd_step_dir), .stop_pos(stop_pos), .stop_neg(stop_neg), .alarm_out(alarm_out), .irq(irq));

// file: sdid_host_model.sv
// Host motion controller model driving the decoder pins
module sdid_host_model (
  input wire logic clk,
  output logic [5:0] general_in,
  output logic cmd_pulse_pos,
  output logic cmd_pulse_neg,
  output logic cmd_dir_pos,
  output logic cmd_dir_neg
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pulse pair idles low, direction positive
  initial
  begin
    general_in = 6'h00;
    cmd_pulse_pos = 1'b0;
    cmd_pulse_neg = 1'b1;
    cmd_dir_pos = 1'b1;
    cmd_dir_neg = 1'b0;
  end

  task set_pin(input int i, input logic v);
    general_in[i] <= v;
  endtask

  // Direction settles first, pulse high then low gap
  task pulse(input logic dir);
    cmd_dir_pos <= dir;
    cmd_dir_neg <= !dir;
    repeat (3) @(posedge clk);
    cmd_pulse_pos <= 1'b1;
    cmd_pulse_neg <= 1'b0;
    repeat (3) @(posedge clk);
    cmd_pulse_pos <= 1'b0;
    cmd_pulse_neg <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
endmodule // sdid_host_model

// file: tb.sv
// Self-checking bench for the servo drive input decoder
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus, reset and fault inputs
  logic clk = 1'b0;
  logic nrst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic fault_req;
  logic [11:0] fault_code;
  logic fault_clearable;
  // Error flag of the last transfer
  logic rd_err;
  // Design outputs and pins
  logic [31:0] prdata, rd;
  logic pready, pslverr, motor_power_en, cmd_step, cmd_step_dir, stop_pos, stop_neg, deviation_clear;
  logic gain_sel, torque_limit_sel, alarm_out, irq, cmd_pulse_pos, cmd_pulse_neg, cmd_dir_pos, cmd_dir_neg;
  logic [1:0] scaling_sel, damping_sel;
  logic [11:0] alarm_code;
  logic [5:0] general_in;
  logic [5:0] sel_exp [7:12];
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int steps = 0;
  int clears = 0;

  always #5 clk = ~clk;

  sdid_decoder #(.PINS(6)) u_sdid_decoder (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .general_in(general_in), .cmd_pulse_pos(cmd_pulse_pos), .cmd_pulse_neg(cmd_pulse_neg),
    .cmd_dir_pos(cmd_dir_pos), .cmd_dir_neg(cmd_dir_neg), .fault_req(fault_req), .fault_code(fault_code),
    .fault_clearable(fault_clearable), .motor_power_en(motor_power_en), .cmd_step(cmd_step),
    .cmd_step_dir(cmd_step_dir), .stop_pos(stop_pos), .stop_neg(stop_neg), .deviation_clear(deviation_clear),
    .scaling_sel(scaling_sel), .damping_sel(damping_sel), .gain_sel(gain_sel),
    .torque_limit_sel(torque_limit_sel), .alarm_out(alarm_out), .alarm_code(alarm_code), .irq(irq));

  sdid_host_model u_sdid_host_model (.clk(clk), .general_in(general_in), .cmd_pulse_pos(cmd_pulse_pos),
    .cmd_pulse_neg(cmd_pulse_neg), .cmd_dir_pos(cmd_dir_pos), .cmd_dir_neg(cmd_dir_neg));

  // Count steps, clear cycles and the cycle ceiling
  always @(posedge clk)
  begin
    cycles++;
    if (cmd_step === 1'b1)
      steps++;
    if (deviation_clear === 1'b1)
      clears++;
    if (cycles == 5000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  // One APB transfer, request held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // Pin change, then time for sync and output stage
  task pin(input int i, input logic v);
    u_sdid_host_model.set_pin(i, v);
    repeat (5) @(posedge clk);
  endtask

  task report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sel_exp = '{6'h10, 6'h20, 6'h04, 6'h08, 6'h02, 6'h01};
    {nrst, psel, penable, pwrite, paddr, pwdata, fault_req, fault_code} <= '0;
    fault_clearable <= 1'b1;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(alarm_out, 1'b1)
    rdc(sdid_pkg::ADDR_CTRL, 32'h2A);
    for (int i = 0; i < 6; i++)
      rdc(sdid_pkg::ADDR_INSEL0 + 8'(4 * i), 32'(i + 1));
    `CHK({scaling_sel, damping_sel, gain_sel, torque_limit_sel}, 6'h00)
    rdc(8'h40, 32'h0);
    `CHK(rd_err, 1'b1)
    u_sdid_host_model.pulse(1'b1);
    `CHK(steps, 0)
    `CHK(cmd_step_dir, 1'b0)
    pin(0, 1'b1);
    `CHK(motor_power_en, 1'b1)
    apb(1'b1, sdid_pkg::ADDR_CTRL, 32'h2B);
    u_sdid_host_model.pulse(1'b1);
    u_sdid_host_model.pulse(1'b0);
    `CHK(steps, 2)
    `CHK(cmd_step_dir, 1'b0)
    apb(1'b1, sdid_pkg::ADDR_CTRL, 32'h0B);
    pin(3, 1'b1);
    u_sdid_host_model.pulse(1'b1);
    `CHK(steps, 2)
    pin(3, 1'b0);
    u_sdid_host_model.pulse(1'b1);
    `CHK(steps, 3)
    apb(1'b1, sdid_pkg::ADDR_CTRL, 32'h09);
    pin(5, 1'b1);
    `CHK(stop_pos, 1'b1)
    u_sdid_host_model.pulse(1'b1);
    u_sdid_host_model.pulse(1'b0);
    `CHK(steps, 4)
    pin(5, 1'b0);
    pin(4, 1'b1);
    `CHK(stop_neg, 1'b1)
    u_sdid_host_model.pulse(1'b0);
    `CHK(steps, 4)
    pin(4, 1'b0);
    pin(2, 1'b1);
    pin(2, 1'b0);
    `CHK(clears, 1)
    rdc(sdid_pkg::ADDR_INT_STAT, 32'h0E);
    apb(1'b1, sdid_pkg::ADDR_INT_STAT, 32'h0F);
    rdc(sdid_pkg::ADDR_INT_STAT, 32'h0);
    apb(1'b1, sdid_pkg::ADDR_CTRL, 32'h03);
    pin(2, 1'b1);
    `CHK(deviation_clear, 1'b1)
    pin(2, 1'b0);
    `CHK(deviation_clear, 1'b0)
    apb(1'b1, 8'h0C, 32'h01);
    pin(0, 1'b0);
    pin(2, 1'b1);
    `CHK(motor_power_en, 1'b0)
    `CHK(deviation_clear, 1'b1)
    pin(2, 1'b0);
    for (int f = 7; f <= 12; f++)
    begin
      apb(1'b1, sdid_pkg::ADDR_INSEL0, 32'(f));
      pin(0, 1'b1);
      `CHK({scaling_sel, damping_sel, gain_sel, torque_limit_sel}, sel_exp[f])
      `CHK(damping_sel, sel_exp[f][3:2])
      `CHK(gain_sel, sel_exp[f][1])
      `CHK(torque_limit_sel, sel_exp[f][0])
      pin(0, 1'b0);
    end
    apb(1'b1, sdid_pkg::ADDR_INSEL0, 32'h1B);
    repeat (4) @(posedge clk);
    `CHK(gain_sel, 1'b1)
    apb(1'b1, 8'h14, 32'h0D);
    pin(4, 1'b1);
    `CHK(alarm_out, 1'b0)
    `CHK(alarm_code, 12'h570)
    `CHK(irq, 1'b0)
    apb(1'b1, sdid_pkg::ADDR_INT_MASK, 32'h1);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    pin(1, 1'b1);
    pin(1, 1'b0);
    `CHK(alarm_out, 1'b0)
    pin(4, 1'b0);
    pin(1, 1'b1);
    `CHK(alarm_out, 1'b1)
    pin(1, 1'b0);
    apb(1'b1, sdid_pkg::ADDR_INT_STAT, 32'h1);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    fault_code <= 12'h123;
    fault_clearable <= 1'b0;
    fault_req <= 1'b1;
    repeat (3) @(posedge clk);
    fault_req <= 1'b0;
    pin(1, 1'b1);
    pin(1, 1'b0);
    `CHK(alarm_out, 1'b0)
    `CHK(alarm_code, 12'h123)
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(alarm_out, 1'b1)
    rdc(sdid_pkg::ADDR_CTRL, 32'h2A);
    report_and_stop();
  end
endmodule // tb
